/* File: tb/cimo_ref_src.sv */
// Partner model: primary and secondary reference clock sources
`timescale 1ns/1ps
module cimo_ref_src #(
  parameter int PRI_HALF = 3,
  parameter int SEC_HALF = 5
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  // Control
  input  wire logic stop_pri_i,
  // Reference outputs
  output logic      pri_clk_o,
  output logic      sec_clk_o,
  output logic      pri_los_o,
  output logic      sec_los_o
);
  int pri_cnt;
  int sec_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // Primary source; a stopped source parks low, as a dead oscillator would
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pri_cnt   <= 0;
      pri_clk_o <= 1'b0;
    end
    else if (stop_pri_i)
      pri_clk_o <= 1'b0;
    else if (pri_cnt == PRI_HALF - 1)
    begin
      pri_cnt   <= 0;
      pri_clk_o <= ~pri_clk_o;
    end
    else
      pri_cnt <= pri_cnt + 1;
  end
  // Secondary source runs free
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sec_cnt   <= 0;
      sec_clk_o <= 1'b0;
    end
    else if (sec_cnt == SEC_HALF - 1)
    begin
      sec_cnt   <= 0;
      sec_clk_o <= ~sec_clk_o;
    end
    else
      sec_cnt <= sec_cnt + 1;
  end
  // Primary loss flag follows the stop request; secondary flag is never raised
  assign pri_los_o = stop_pri_i;
  assign sec_los_o = 1'b0;
endmodule

/* File: tb/tb_top.sv */
// Testbench: APB driver, result queue and decode checks for cimo_cfg
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i, arst_n_i, psel, penable, pwrite, pin, stop_pri;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        pready, pslverr, pri_clk, sec_clk, pri_los, sec_los;
  logic        dev_run, pll_ref, cfg_warn;
  logic [15:0] v, out_w;
  logic [33:0] note_q[$];
  logic [33:0] note;
  cimo_pkg::cimo_ref_t ref_ctl;
  cimo_pkg::cimo_out_t out0, out1;
  int bad_count, checks_done, k, t;
  localparam logic [7:0] RA = cimo_pkg::REF_CFG_OFFS;
  localparam logic [7:0] OA = cimo_pkg::OUT01_CFG_OFFS;
  localparam logic [7:0] CA = cimo_pkg::RUN_CTL_OFFS;

  cimo_cfg dut_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_sel_pin_i(pin), .pri_clk_i(pri_clk),
    .sec_clk_i(sec_clk), .pri_los_i(pri_los), .sec_los_i(sec_los), .ref_ctl_o(ref_ctl),
    .out0_o(out0), .out1_o(out1), .dev_run_o(dev_run), .pll_ref_o(pll_ref),
    .cfg_warn_o(cfg_warn));
  cimo_ref_src src_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .stop_pri_i(stop_pri),
    .pri_clk_o(pri_clk), .sec_clk_o(sec_clk), .pri_los_o(pri_los), .sec_los_o(sec_los));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One APB transfer; the expected answer goes to the queue first
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic err, input logic [31:0] e);
    int n;
    note_q.push_back({~w, err, e});
    @(posedge core_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk_i);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      bad_count++;
      end_of_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk_i);
  endtask

  // Completed transfers are matched against the oldest note
  always @(posedge core_clk_i)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      note = note_q.pop_front();
      cmp("pslverr", 32'(note[32]), 32'(pslverr));
      if (note[33])
        cmp("prdata", note[31:0], prdata);
    end
  end

  // Expected decode of a reference word
  task automatic chk_ref(input logic [15:0] c);
    logic warn;
    warn = (!c[13] && !(c[5] && c[2])) || (out_w[15:9] != 7'h00);
    cmp("delay", 32'(c[14]), 32'(ref_ctl.delay_en));
    cmp("reshape", 32'(c[15]), 32'(ref_ctl.reshape_en));
    cmp("manual", 32'(c[13]), 32'(ref_ctl.manual));
    cmp("use_sec", 32'(c[13] & c[12] & pin), 32'(ref_ctl.use_sec));
    cmp("div", 32'(c[11:8]) + 32'd1, 32'(ref_ctl.div_ratio));
    cmp("sec_rx", 32'(c[7:6]), 32'(ref_ctl.sec_rx));
    cmp("sec_en", 32'(c[5]), 32'(ref_ctl.sec_en));
    cmp("pri_rx", c[4] ? 32'd2 : 32'(c[4:3]), 32'(ref_ctl.pri_rx));
    cmp("pri_en", 32'(c[2]), 32'(ref_ctl.pri_en));
    cmp("rails", 32'(c[1:0]), 32'({ref_ctl.sec_hv, ref_ctl.pri_hv}));
    xfer(1'b0, RA, 32'h0, 1'b0, {14'h0, warn, c[13] & c[12] & pin, c});
  endtask

  function automatic logic [31:0] drv(input logic [1:0] c);
    return (c == 2'h2) ? 32'd1 : (c == 2'h3) ? 32'd2 : 32'd0;
  endfunction

  // Bounded wait for the gated outputs, then compare each field
  task automatic chk_out(input logic [15:0] w, input logic run);
    logic [1:0] m0, m1;
    logic ok;
    m0 = w[2:1];
    m1 = w[6:5];
    ok = 1'b0;
    for (t = 0; t < 80 && !ok; t++)
    begin
      @(negedge core_clk_i);
      ok = (out0.active === (run && m0 != 2'h0)) && (out1.active === (run && m1 != 2'h0))
           && (!run || !m0[1] || out0.level === m0[0]) && (!run || !m1[1] || out1.level === m1[0]);
    end
    cmp("drv0", drv(w[4:3]), 32'(out0.drv));
    cmp("drv1", drv(w[8:7]), 32'(out1.drv));
    cmp("act0", 32'(run && m0 != 2'h0), 32'(out0.active));
    cmp("act1", 32'(run && m1 != 2'h0), 32'(out1.active));
    if (run && m0[1])
      cmp("lvl0", 32'(m0[0]), 32'(out0.level));
    if (run && m1[1])
      cmp("lvl1", 32'(m1[0]), 32'(out1.level));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    arst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pin = 1'b0; stop_pri = 1'b0; out_w = 16'h0000;
    bad_count = 0; checks_done = 0; rnd = 32'h3aa2_2cf2;
    repeat (8) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    // Reset values; auto mode without enables raises the warning bit
    xfer(1'b0, RA, 32'h0, 1'b0, 32'h0002_0000);
    xfer(1'b0, OA, 32'h0, 1'b0, 32'h0000_0000);
    xfer(1'b0, CA, 32'h0, 1'b0, 32'h0000_0000);
    xfer(1'b1, 8'h20, 32'hffff_ffff, 1'b1, 32'h0);
    xfer(1'b0, 8'h20, 32'h0, 1'b1, 32'h0000_0000);
    xfer(1'b1, CA, 32'h0000_0040, 1'b0, 32'h0);
    cmp("run", 32'd1, 32'(dev_run));
    // Table of codes, then random words
    for (k = 0; k < 24; k++)
    begin
      rnd = xs(rnd);
      v = (k < 16) ? {k[1:0], k[2], k[3], k[3:0], k[1:0], 1'b1, k[1:0], 1'b1, k[1:0]} : rnd[15:0];
      if (!v[13])
        v = v | 16'h0024;
      @(posedge core_clk_i);
      pin <= (k < 16) ? k[0] : rnd[20];
      xfer(1'b1, RA, {16'h0, v}, 1'b0, 32'h0);
      chk_ref(v);
    end
    // Divided reference: ratio 4 of a 6-cycle primary is 24 core cycles
    xfer(1'b1, RA, 32'h0000_232d, 1'b0, 32'h0);
    for (t = 0; t < 200 && pll_ref !== 1'b1; t++)
      @(negedge core_clk_i);
    for (t = 0; t < 200 && pll_ref !== 1'b0; t++)
      @(negedge core_clk_i);
    for (t = 0; t < 200 && pll_ref !== 1'b1; t++)
      @(negedge core_clk_i);
    cmp("pll_period", 32'd24, 32'(t + 1));
    // Nonzero reserved bits are flagged and kept
    out_w = 16'hfe00;
    xfer(1'b1, OA, {16'h0, out_w}, 1'b0, 32'h0);
    cmp("warn", 32'd1, 32'(cfg_warn));
    xfer(1'b0, OA, 32'h0, 1'b0, 32'h0000_fe00);
    // Every driver and enable code on both channels
    for (k = 0; k < 16; k++)
    begin
      out_w = {7'h00, ~k[1:0], ~k[3:2], k[1:0], k[3:2], 1'b0};
      xfer(1'b1, OA, {16'h0, out_w}, 1'b0, 32'h0);
      chk_out(out_w, 1'b1);
    end
    // Run low forces outputs off but keeps the registers
    xfer(1'b1, CA, 32'h0, 1'b0, 32'h0);
    chk_out(out_w, 1'b0);
    xfer(1'b0, OA, 32'h0, 1'b0, {16'h0, out_w});
    xfer(1'b0, RA, 32'h0, 1'b0, 32'h0000_232d);
    // Automatic choice moves to secondary on primary loss
    xfer(1'b1, RA, 32'h0000_1024, 1'b0, 32'h0);
    cmp("auto_pri", 32'd0, 32'(ref_ctl.use_sec));
    @(posedge core_clk_i);
    stop_pri <= 1'b1;
    for (t = 0; t < 100 && ref_ctl.use_sec !== 1'b1; t++)
      @(negedge core_clk_i);
    cmp("auto_sec", 32'd1, 32'(ref_ctl.use_sec));
    end_of_test();
  end
endmodule

/* File: verilog/cimo_cfg.sv */
// Reference input mux and output pair 0/1 configuration with APB slave
//
// Notes on behaviour
// - Shaping field 15:14 picks none, delay, reshape or both; zero is the reset value.
// - Bit 13 low selects automatic reference choice, high selects manual choice.
// - In manual mode bit 12 low takes primary, high takes secondary only while select pin high.
// - The manual choice bit is ignored while automatic mode is set.
// - Field 11:8 sets the primary pre-divider as value plus one, 1 to 16.
// - Field 7:6 picks the secondary receiver type and bit 5 enables it.
// - Field 4:3 picks the primary receiver type, codes 10 and 11 both CMOS, bit 2 enables it.
// - Bits 1 and 0 declare secondary and primary rails, 0 for 1.8 V, 1 for 2.5/3.3 V.
// - Driver fields 8:7 and 4:3 map 00/01 to LVDS, 10 to CML, 11 to emitter-coupled.
// - Enable fields 6:5 and 2:1 mean off, pass clock, hold low, hold high.
// - Run control bit low holds the device in reset yet keeps all register contents.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module cimo_cfg (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Reference pins
  input  wire logic        ref_sel_pin_i,
  input  wire logic        pri_clk_i,
  input  wire logic        sec_clk_i,
  input  wire logic        pri_los_i,
  input  wire logic        sec_los_i,
  // Decoded control
  output cimo_pkg::cimo_ref_t ref_ctl_o,
  output cimo_pkg::cimo_out_t out0_o,
  output cimo_pkg::cimo_out_t out1_o,
  output logic             dev_run_o,
  output logic             pll_ref_o,
  output logic             cfg_warn_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [15:0] ref_cfg_q;
  logic [15:0] out_cfg_q;
  logic        run_q;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic        use_sec;

  // Single-cycle access phase; unmapped addresses flag an error
  assign wr_en   = psel && penable && pwrite;
  // Read data is captured in setup so it already stands in the access phase
  assign rd_en   = psel && !penable && !pwrite;
  assign hit     = (paddr == cimo_pkg::REF_CFG_OFFS) || (paddr == cimo_pkg::OUT01_CFG_OFFS)
                   || (paddr == cimo_pkg::RUN_CTL_OFFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Reference config word; survives run control low
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ref_cfg_q <= cimo_pkg::REF_CFG_RST;
    else if (wr_en && paddr == cimo_pkg::REF_CFG_OFFS)
      ref_cfg_q <= pwdata[15:0];
  end

  // Output pair word; reserved bits stored as written so the fault stays visible
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      out_cfg_q <= cimo_pkg::OUT01_CFG_RST;
    else if (wr_en && paddr == cimo_pkg::OUT01_CFG_OFFS)
      out_cfg_q <= pwdata[15:0];
  end

  // Run control bit
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      run_q <= cimo_pkg::RUN_CTL_RST;
    else if (wr_en && paddr == cimo_pkg::RUN_CTL_OFFS)
      run_q <= pwdata[cimo_pkg::RUN_BIT];
  end

  // Registered read data; status of the chosen source in bit 16 of the ref word
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      case (paddr)
        cimo_pkg::REF_CFG_OFFS:   prdata <= {14'h0000, cfg_warn_o, use_sec, ref_cfg_q};
        cimo_pkg::OUT01_CFG_OFFS: prdata <= {16'h0000, out_cfg_q};
        cimo_pkg::RUN_CTL_OFFS:   prdata <= {25'h000_0000, run_q, 6'h00};
        default:                  prdata <= 32'h0000_0000;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference path decode

  logic       manual;
  logic       auto_sec_q;
  logic [4:0] div_ratio;
  logic [3:0] div_cnt_q;
  logic       div_out_q;
  logic       pri_edge;
  logic       pri_d_q;

  assign manual = ref_cfg_q[cimo_pkg::AUTOMAN_BIT];

  // Auto mode sticks with primary until it is lost, then falls back
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      auto_sec_q <= 1'b0;
    else if (pri_los_i && !sec_los_i)
      auto_sec_q <= 1'b1;
    else if (sec_los_i && !pri_los_i)
      auto_sec_q <= 1'b0;
  end

  // Manual choice bit only counts in manual mode, and secondary needs the pin
  assign use_sec = manual ? (ref_cfg_q[cimo_pkg::CHOICE_BIT] && ref_sel_pin_i)
                          : auto_sec_q;

  assign div_ratio = {1'b0, ref_cfg_q[cimo_pkg::PREDIV_MSB:cimo_pkg::PREDIV_LSB]} + 5'd1;

  // Primary pre-divider: counts primary rising edges, fires a one-cycle pulse at ratio
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pri_d_q <= 1'b0;
    else
      pri_d_q <= pri_clk_i;
  end
  assign pri_edge = pri_clk_i && !pri_d_q;

  // Divide counter, held in reset while run control is low
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_cnt_q <= 4'h0;
      div_out_q <= 1'b0;
    end
    else if (!run_q)
    begin
      div_cnt_q <= 4'h0;
      div_out_q <= 1'b0;
    end
    else if (pri_edge)
    begin
      if ({1'b0, div_cnt_q} + 5'd1 >= div_ratio)
      begin
        div_cnt_q <= 4'h0;
        div_out_q <= 1'b1;
      end
      else
      begin
        div_cnt_q <= div_cnt_q + 4'h1;
        div_out_q <= 1'b0;
      end
    end
    else
      div_out_q <= 1'b0; // one-cycle pulse; a held level would stall ratio 1
  end

  // Reference to PLL, gated by buffer enables
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pll_ref_o <= 1'b0;
    else if (!run_q)
      pll_ref_o <= 1'b0;
    else if (use_sec)
      pll_ref_o <= sec_clk_i && ref_cfg_q[cimo_pkg::SECEN_BIT];
    else
      pll_ref_o <= div_out_q && ref_cfg_q[cimo_pkg::PRIEN_BIT];
  end

  // Decoded reference control bundle
  always_comb
  begin
    ref_ctl_o            = '0;
    ref_ctl_o.delay_en   = ref_cfg_q[cimo_pkg::SHAPING_LSB];
    ref_ctl_o.reshape_en = ref_cfg_q[cimo_pkg::SHAPING_MSB];
    ref_ctl_o.manual     = manual;
    ref_ctl_o.use_sec    = use_sec;
    ref_ctl_o.div_ratio  = div_ratio;
    ref_ctl_o.sec_rx     = cimo_pkg::cimo_rx_t'(
                             ref_cfg_q[cimo_pkg::SECRX_MSB:cimo_pkg::SECRX_LSB]);
    ref_ctl_o.pri_rx     = ref_cfg_q[cimo_pkg::PRIRX_MSB] ? cimo_pkg::RX_CMOS
                           : cimo_pkg::cimo_rx_t'(ref_cfg_q[cimo_pkg::PRIRX_MSB:cimo_pkg::PRIRX_LSB]);
    ref_ctl_o.sec_en     = ref_cfg_q[cimo_pkg::SECEN_BIT];
    ref_ctl_o.pri_en     = ref_cfg_q[cimo_pkg::PRIEN_BIT];
    ref_ctl_o.sec_hv     = ref_cfg_q[cimo_pkg::SECRAIL_BIT];
    ref_ctl_o.pri_hv     = ref_cfg_q[cimo_pkg::PRIRAIL_BIT];
  end

  // Warning: auto mode without both buffers, or reserved output bits set
  assign cfg_warn_o = (!manual && !(ref_cfg_q[cimo_pkg::SECEN_BIT]
                       && ref_cfg_q[cimo_pkg::PRIEN_BIT]))
                      || (out_cfg_q[cimo_pkg::OUT_RSV_MSB:cimo_pkg::OUT_RSV_LSB] != 7'h00);

  assign dev_run_o = run_q;

  ////////////////////////////////////////////////////////////////////////////
  // Output channels 0 and 1

  logic [1:0] act;
  logic [1:0] lvl;

  // Driver type: 00 and 01 both LVDS
  function automatic cimo_pkg::cimo_drv_t drv_dec(input logic [1:0] code);
    drv_dec = (code == 2'h2) ? cimo_pkg::DRV_CML
            : (code == 2'h3) ? cimo_pkg::DRV_ECL : cimo_pkg::DRV_LVDS;
  endfunction

  cimo_out_gate u_gate0 (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .run_i      (run_q),
    .mode_i     (out_cfg_q[cimo_pkg::EN0_MSB:cimo_pkg::EN0_LSB]),
    .ref_clk_i  (pll_ref_o),
    .active_o   (act[0]),
    .out_o      (lvl[0])
  );

  cimo_out_gate u_gate1 (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .run_i      (run_q),
    .mode_i     (out_cfg_q[cimo_pkg::EN1_MSB:cimo_pkg::EN1_LSB]),
    .ref_clk_i  (pll_ref_o),
    .active_o   (act[1]),
    .out_o      (lvl[1])
  );

  // Output bundles
  assign out0_o = '{drv: drv_dec(out_cfg_q[cimo_pkg::DRV0_MSB:cimo_pkg::DRV0_LSB]),
                    active: act[0], level: lvl[0]};
  assign out1_o = '{drv: drv_dec(out_cfg_q[cimo_pkg::DRV1_MSB:cimo_pkg::DRV1_LSB]),
                    active: act[1], level: lvl[1]};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_shaping;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      ref_ctl_o.delay_en == ref_cfg_q[14] && ref_ctl_o.reshape_en == ref_cfg_q[15];
  endproperty
  a_shaping: assert property (p_shaping) else $error("shaping decode wrong");

  property p_auto_ignores;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      !ref_cfg_q[13] |-> (use_sec == auto_sec_q);
  endproperty
  a_auto_ignores: assert property (p_auto_ignores) else $error("choice bit used in auto");

  property p_manual_sec;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      ref_cfg_q[13] |-> (use_sec == (ref_cfg_q[12] && ref_sel_pin_i));
  endproperty
  a_manual_sec: assert property (p_manual_sec) else $error("manual choice wrong");

  property p_mode_flag;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      ref_ctl_o.manual == ref_cfg_q[13];
  endproperty
  a_mode_flag: assert property (p_mode_flag) else $error("mode bit decode wrong");

  property p_div;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      div_ratio == ({1'b0, ref_cfg_q[11:8]} + 5'h01);
  endproperty
  a_div: assert property (p_div) else $error("divider ratio wrong");

  property p_pri_rx;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      ref_cfg_q[4] |-> ref_ctl_o.pri_rx == cimo_pkg::RX_CMOS;
  endproperty
  a_pri_rx: assert property (p_pri_rx) else $error("primary rx decode wrong");

  property p_run_hold;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (!run_q && !(wr_en && paddr == cimo_pkg::REF_CFG_OFFS)) |=> $stable(ref_cfg_q) && !pll_ref_o;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run low lost state");

  property p_drv;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      out_cfg_q[4:3] == 2'h3 |-> out0_o.drv == cimo_pkg::DRV_ECL;
  endproperty
  a_drv: assert property (p_drv) else $error("driver decode wrong");

  property p_static;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (run_q && out_cfg_q[2:1] == 2'h3 && !pll_ref_o) ##1 (run_q && out_cfg_q[2:1] == 2'h3)
      |=> lvl[0];
  endproperty
  a_static: assert property (p_static) else $error("static high missing");

  property p_rails;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      ref_ctl_o.sec_hv == ref_cfg_q[1] && ref_ctl_o.pri_hv == ref_cfg_q[0]
      && ref_ctl_o.sec_rx == cimo_pkg::cimo_rx_t'(ref_cfg_q[7:6]);
  endproperty
  a_rails: assert property (p_rails) else $error("rail or sec rx decode wrong");

  // Divider output must be a pulse, never a held level
  property p_div_pulse;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      div_out_q |=> !div_out_q;
  endproperty
  a_div_pulse: assert property (p_div_pulse) else $error("divider pulse too long");

  // Last primary edge of a period restarts the count and fires the pulse
  property p_div_wrap;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (run_q && pri_edge && ({1'b0, div_cnt_q} + 5'h01 >= div_ratio))
      |=> div_out_q && div_cnt_q == 4'h0;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider wrap wrong");

  // Run control low switches both channels off one cycle later
  property p_run_off;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      !run_q |=> !act[0] && !act[1];
  endproperty
  a_run_off: assert property (p_run_off) else $error("output on while held");

  property p_drv1;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      out_cfg_q[8:7] == 2'h2 |-> out1_o.drv == cimo_pkg::DRV_CML;
  endproperty
  a_drv1: assert property (p_drv1) else $error("channel 1 driver decode wrong");

  property p_drv0_lvds;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      out_cfg_q[4:3] == 2'h0 |-> out0_o.drv == cimo_pkg::DRV_LVDS;
  endproperty
  a_drv0_lvds: assert property (p_drv0_lvds) else $error("channel 0 lvds decode wrong");

  // Reserved output bits set must always raise the warning
  property p_warn_rsv;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      out_cfg_q[15:9] != 7'h00 |-> cfg_warn_o;
  endproperty
  a_warn_rsv: assert property (p_warn_rsv) else $error("reserved bits not flagged");

endmodule

/* File: verilog/cimo_out_gate.sv */
// Glitch-free output channel gate: mode changes land on clock-low while run is high
`timescale 1ns/1ps
module cimo_out_gate (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       ref_clk_i,
  // Output
  output logic            active_o,
  output logic            out_o
);

  logic [1:0] mode_q;
  logic       out_q;

  // Mode taken over while the reference is low, so no cut pulse; run low forces off at the next clock whatever the reference
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mode_q <= cimo_pkg::EN_OFF;
    else if (!ref_clk_i || !run_i)
      mode_q <= run_i ? mode_i : cimo_pkg::EN_OFF;
  end

  // Registered output level per mode
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      out_q <= 1'b0;
    else
      case (mode_q)
        cimo_pkg::EN_PASS: out_q <= ref_clk_i;
        cimo_pkg::EN_HIGH: out_q <= 1'b1;
        default:           out_q <= 1'b0;
      endcase
  end

  assign active_o = (mode_q != cimo_pkg::EN_OFF);
  assign out_o    = out_q;

  // Safe moment check: mode never changes while reference is high and running
  property p_switch_low;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (ref_clk_i && $past(run_i) && run_i) |=> $stable(mode_q);
  endproperty
  a_switch_low: assert property (p_switch_low) else $error("mode moved on high");

endmodule

/* File: verilog/cimo_pkg.sv */
// Package: register map, field layout, encodings and carrier structs
package cimo_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] REF_CFG_OFFS   = 8'h10;
  localparam logic [7:0] OUT01_CFG_OFFS = 8'h14;
  localparam logic [7:0] RUN_CTL_OFFS   = 8'h0c;

  // Reset values
  localparam logic [15:0] REF_CFG_RST   = 16'h0000;
  localparam logic [15:0] OUT01_CFG_RST = 16'h0000;
  localparam logic        RUN_CTL_RST   = 1'b0;

  // Reference config field positions
  localparam int SHAPING_MSB  = 15;
  localparam int SHAPING_LSB  = 14;
  localparam int AUTOMAN_BIT  = 13;
  localparam int CHOICE_BIT   = 12;
  localparam int PREDIV_MSB   = 11;
  localparam int PREDIV_LSB   = 8;
  localparam int SECRX_MSB    = 7;
  localparam int SECRX_LSB    = 6;
  localparam int SECEN_BIT    = 5;
  localparam int PRIRX_MSB    = 4;
  localparam int PRIRX_LSB    = 3;
  localparam int PRIEN_BIT    = 2;
  localparam int SECRAIL_BIT  = 1;
  localparam int PRIRAIL_BIT  = 0;

  // Output pair config field positions, then the run control bit
  localparam int OUT_RSV_MSB  = 15;
  localparam int OUT_RSV_LSB  = 9;
  localparam int DRV1_MSB     = 8;
  localparam int DRV1_LSB     = 7;
  localparam int EN1_MSB      = 6;
  localparam int EN1_LSB      = 5;
  localparam int DRV0_MSB     = 4;
  localparam int DRV0_LSB     = 3;
  localparam int EN0_MSB      = 2;
  localparam int EN0_LSB      = 1;
  localparam int RUN_BIT      = 6;

  // Output enable codes
  localparam logic [1:0] EN_OFF    = 2'h0;
  localparam logic [1:0] EN_PASS   = 2'h1;
  localparam logic [1:0] EN_LOW    = 2'h2;
  localparam logic [1:0] EN_HIGH   = 2'h3;

  // Decoded receiver and driver kinds
  typedef enum logic [1:0] {RX_CML, RX_LVDS, RX_CMOS, RX_XTAL} cimo_rx_t;
  typedef enum logic [1:0] {DRV_LVDS, DRV_CML, DRV_ECL} cimo_drv_t;

  // Per-channel output state
  typedef struct packed {
    cimo_drv_t  drv;
    logic       active;
    logic       level;
  } cimo_out_t;

  // Reference path state
  typedef struct packed {
    logic       delay_en;
    logic       reshape_en;
    logic       manual;
    logic       use_sec;
    logic [4:0] div_ratio;
    cimo_rx_t   pri_rx;
    cimo_rx_t   sec_rx;
    logic       pri_en;
    logic       sec_en;
    logic       pri_hv;
    logic       sec_hv;
  } cimo_ref_t;

endpackage
